// file: rtl/lcm_pkg.sv
// Package: constants and carrier types for the line channel control block
package lcm_pkg;

  // Clock rate and frequency-judging window
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned FREQ_WINDOW_CYC = 8192;
  localparam int unsigned CNT_W           = 14;
  // 0.5 % expressed as one part in 200
  localparam int unsigned PPM_DIV         = 200;
  localparam int unsigned PROD_W          = 22;

  // Drive monitor: 128 +/- 32 tx periods, fixed threshold at the nominal figure
  localparam int unsigned DMON_W          = 8;
  localparam logic [7:0]  DMON_LIMIT      = 8'h80;
  localparam logic [7:0]  DMON_ONE        = 8'h01;

  // Synchroniser lane positions
  localparam int unsigned SYN_W           = 8;
  localparam int unsigned SYN_TXCLK       = 0;
  localparam int unsigned SYN_MON_POS     = 1;
  localparam int unsigned SYN_MON_NEG     = 2;
  localparam int unsigned SYN_RECCLK      = 3;
  localparam int unsigned SYN_REFCLK      = 4;
  localparam int unsigned SYN_SIGNAL      = 5;
  localparam int unsigned SYN_TXON_PIN    = 6;
  localparam int unsigned SYN_SPARE       = 7;

  // Static configuration bits of one channel
  typedef struct packed {
    logic host_mode;
    logic single_rail_select;
    logic rate_e3;
    logic build_out_disable;
    logic internal_drive_monitor_sel;
    logic drive_monitor_int_enable;
    logic transmitter_on;
    logic equalizer_in;
    logic rx_line_monitor_gain;
  } lcm_cfg_t;

  // Two rails of transmit data
  typedef struct packed {
    logic pos;
    logic neg;
  } lcm_rail_t;

endpackage

// file: rtl/lcm_freq_cmp.sv
// Compares recovered and reference clock edge counts over a common window
`timescale 1ns/1ps
module lcm_freq_cmp #(
  parameter int unsigned WINDOW_CYC = lcm_pkg::FREQ_WINDOW_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic rec_edge,
  input  wire logic ref_edge,
  output logic      off_freq_ff,
  output logic      done_ff
);
  import lcm_pkg::*;

  logic [CNT_W-1:0]  win_ff;
  logic [CNT_W-1:0]  rec_cnt_ff;
  logic [CNT_W-1:0]  ref_cnt_ff;
  logic [CNT_W-1:0]  diff;
  logic [PROD_W-1:0] diff_scaled;
  logic              win_end;

  assign win_end     = (win_ff == CNT_W'(WINDOW_CYC - 1));
  assign diff        = (rec_cnt_ff > ref_cnt_ff) ? rec_cnt_ff - ref_cnt_ff
                                                 : ref_cnt_ff - rec_cnt_ff;
  assign diff_scaled = PROD_W'(diff) * PROD_W'(PPM_DIV);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_ff <= '0;
    end else if (win_end) begin
      win_ff <= '0;
    end else begin
      win_ff <= win_ff + CNT_W'(1);
    end
  end

  // Both counts restart together so they share exactly one window [RQ21]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rec_cnt_ff <= '0;
      ref_cnt_ff <= '0;
    end else if (win_end) begin
      rec_cnt_ff <= '0;
      ref_cnt_ff <= '0;
    end else begin
      rec_cnt_ff <= rec_cnt_ff + CNT_W'(rec_edge);
      ref_cnt_ff <= ref_cnt_ff + CNT_W'(ref_edge);
    end
  end

  // Off frequency when diff/ref exceeds 1/200 [RQ21]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      off_freq_ff <= 1'b1;
      done_ff     <= 1'b0;
    end else begin
      done_ff <= win_end;
      if (win_end) begin
        off_freq_ff <= (diff_scaled > PROD_W'(ref_cnt_ff));
      end
    end
  end

endmodule

// file: rtl/lcm_ctrl.sv
// Channel control: format, build-out, drive monitor, transmitter, receiver and lock
`timescale 1ns/1ps
// How it works
// RQ1 - Dual-rail format turns the encoder off
// RQ2 - Dual-rail passes bipolar violations as data
// RQ3 - Encoder and decoder on only in single-rail
// RQ4 - Build-out enabled when control bit is low
// RQ5 - E3 rate forces build-out off
// RQ6 - Host enables build-out below 225 feet
// RQ7 - 128 quiet tx periods raise alarm, sticky status
// RQ8 - Transitions clear alarm; status stays until read
// RQ9 - Interrupt only when enable bit set
// RQ10 - Select bit picks own driver or monitor inputs
// RQ11 - Transmitter off tri-states both line outputs
// RQ12 - Host mode: bit and pin both required
// RQ13 - Equalizer in when its bit is high
// RQ14 - Host bypasses equalizer below 300 feet
// RQ15 - Monitor-gain bit enables 20 dB stage
// RQ16 - No signal or off frequency declares lock lost
// RQ17 - Lock lost selects reference clock output
// RQ18 - Locked selects the recovered clock output
// RQ19 - Format bit high means single-rail
// RQ20 - Quiet count restarts on every transition
// RQ21 - Frequency judged over a common counting window
module lcm_ctrl #(
  parameter int unsigned WINDOW_CYC = lcm_pkg::FREQ_WINDOW_CYC
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  lcm_pkg::lcm_cfg_t cfg,
  input  lcm_pkg::lcm_rail_t tx_data,
  input  wire logic         tx_rate_clock,
  input  wire logic         transmitter_on_pin,
  input  wire logic         monitor_in_pos,
  input  wire logic         monitor_in_neg,
  input  wire logic         rx_signal_present,
  input  wire logic         rx_recovered_clock,
  input  wire logic         reference_clock_in,
  input  wire logic         status_read,
  output logic              tx_line_pos_o,
  output logic              tx_line_pos_oe,
  output logic              tx_line_neg_o,
  output logic              tx_line_neg_oe,
  output logic              encoder_enable,
  output logic              decoder_enable,
  output logic              bpv_as_data,
  output logic              build_out_enable,
  output logic              equalizer_enable,
  output logic              monitor_gain_enable,
  output logic              drive_monitor_alarm,
  output logic              drive_monitor_int_status,
  output logic              drive_monitor_irq,
  output logic              rx_lock_lost,
  output logic              rx_clock_uses_reference
);
  import lcm_pkg::*;

  logic              rst_meta_ff;
  logic              rst_sync_ff;
  logic [SYN_W-1:0]  sync1_ff;
  logic [SYN_W-1:0]  sync2_ff;
  logic [SYN_W-1:0]  prev_ff;
  logic [SYN_W-1:0]  pins;
  logic [SYN_W-1:0]  rise;
  logic              tx_en;
  logic              mon_pos;
  logic              mon_neg;
  logic              mark_seen_ff;
  logic [DMON_W-1:0] quiet_cnt_ff;
  logic [DMON_W-1:0] nxt_quiet_cnt;
  logic              off_freq;
  logic              win_done;
  logic              in_range;
  logic              status_set;
  logic              enc_ff;
  logic              bo_ff;
  logic              eq_ff;
  logic              gain_ff;
  logic              pos_ff;
  logic              neg_ff;
  logic              oe_ff;
  logic              alarm_ff;
  logic              status_ff;
  logic              irq_ff;
  logic              lol_ff;

  // Release reset through two flops; async assert only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign pins = {1'b0, transmitter_on_pin, rx_signal_present, reference_clock_in,
                 rx_recovered_clock, monitor_in_neg, monitor_in_pos, tx_rate_clock};

  // Only the second stage and beyond are ever read
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;

  // Line format and build-out selection
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      enc_ff  <= 1'b0;
      bo_ff   <= 1'b0;
      eq_ff   <= 1'b0;
      gain_ff <= 1'b0;
    end else begin
      enc_ff  <= cfg.single_rail_select; // [RQ1] [RQ3] [RQ19]
      bo_ff   <= !cfg.build_out_disable && !cfg.rate_e3; // [RQ4] [RQ5]
      eq_ff   <= cfg.equalizer_in; // [RQ13]
      gain_ff <= cfg.rx_line_monitor_gain; // [RQ15]
    end
  end

  assign encoder_enable      = enc_ff;
  assign decoder_enable      = enc_ff; // [RQ3]
  assign bpv_as_data         = !enc_ff; // [RQ2]
  assign build_out_enable    = bo_ff;
  assign equalizer_enable    = eq_ff;
  assign monitor_gain_enable = gain_ff;

  // Host mode needs both bit and pin; the pin alone rules otherwise
  assign tx_en = cfg.host_mode ? (cfg.transmitter_on && sync2_ff[SYN_TXON_PIN])
                               : sync2_ff[SYN_TXON_PIN]; // [RQ12]

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      pos_ff <= tx_en && tx_data.pos;
      neg_ff <= tx_en && tx_data.neg && !cfg.single_rail_select;
      oe_ff  <= tx_en; // [RQ11]
    end
  end

  assign tx_line_pos_o  = pos_ff;
  assign tx_line_neg_o  = neg_ff;
  assign tx_line_pos_oe = oe_ff;
  assign tx_line_neg_oe = oe_ff;

  // Own driver needs no sync; external pins are far-side wiring
  assign mon_pos = cfg.internal_drive_monitor_sel ? pos_ff : sync2_ff[SYN_MON_POS]; // [RQ10]
  assign mon_neg = cfg.internal_drive_monitor_sel ? neg_ff : sync2_ff[SYN_MON_NEG]; // [RQ10]

  // Marks are remembered until the next tx clock edge counts them
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mark_seen_ff <= 1'b0;
    end else if (rise[SYN_TXCLK]) begin
      mark_seen_ff <= 1'b0;
    end else if (mon_pos || mon_neg) begin
      mark_seen_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_quiet_cnt = quiet_cnt_ff;
    if (rise[SYN_TXCLK]) begin
      if (mark_seen_ff || mon_pos || mon_neg) begin
        nxt_quiet_cnt = '0; // [RQ20]
      end else if (quiet_cnt_ff < DMON_LIMIT) begin
        nxt_quiet_cnt = quiet_cnt_ff + DMON_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      quiet_cnt_ff <= '0;
    end else begin
      quiet_cnt_ff <= nxt_quiet_cnt;
    end
  end

  assign status_set = (quiet_cnt_ff >= DMON_LIMIT);

  // Live alarm follows the count; sticky status set wins over read
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      alarm_ff  <= 1'b0;
      status_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      alarm_ff <= status_set; // [RQ7] [RQ8]
      if (status_set) begin
        status_ff <= 1'b1; // [RQ7]
      end else if (status_read) begin
        status_ff <= 1'b0; // [RQ8]
      end
      irq_ff <= status_ff && cfg.drive_monitor_int_enable; // [RQ9]
    end
  end

  assign drive_monitor_alarm      = alarm_ff;
  assign drive_monitor_int_status = status_ff;
  assign drive_monitor_irq        = irq_ff;

  lcm_freq_cmp #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_freq (
    .clock       (clock),
    .rst_n       (rst_sync_ff),
    .rec_edge    (rise[SYN_RECCLK]),
    .ref_edge    (rise[SYN_REFCLK]),
    .off_freq_ff (off_freq),
    .done_ff     (win_done)
  );

  assign in_range = !off_freq;

  // Signal loss acts at once; frequency verdict updates per window
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lol_ff <= 1'b1;
    end else begin
      lol_ff <= !sync2_ff[SYN_SIGNAL] || !in_range; // [RQ16] [RQ18]
    end
  end

  assign rx_lock_lost            = lol_ff;
  assign rx_clock_uses_reference = lol_ff; // [RQ17] [RQ18]

  // Flops still hold reset values on the first edge after release
  a_format_encoder: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ1]
    !$past(cfg.single_rail_select) |-> !encoder_enable && bpv_as_data)
    else $error("encoder on in dual-rail");
  a_single_rail_on: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ3]
    encoder_enable |-> decoder_enable && $past(cfg.single_rail_select))
    else $error("codec not tied to single-rail");
  a_build_out_e3: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ5]
    $past(cfg.rate_e3) |-> !build_out_enable)
    else $error("build-out on at E3");
  a_build_out_bit: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ4]
    $past(rst_sync_ff) && $past(!cfg.rate_e3)
      |-> build_out_enable == !$past(cfg.build_out_disable))
    else $error("build-out not following bit");
  a_tx_off_hiz: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ11]
    !$past(tx_en) |-> !tx_line_pos_oe && !tx_line_neg_oe && !tx_line_pos_o)
    else $error("driver active while off");
  a_host_tx_pin: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ12]
    $past(cfg.host_mode) && !$past(sync2_ff[SYN_TXON_PIN]) |-> !tx_line_pos_oe)
    else $error("host mode ran without pin");
  a_alarm_count: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ7]
    drive_monitor_alarm |-> $past(quiet_cnt_ff) == DMON_LIMIT)
    else $error("alarm without 128 quiet periods");
  a_alarm_sticky: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ8]
    $fell(drive_monitor_alarm) |-> drive_monitor_int_status)
    else $error("status cleared with alarm");
  a_count_restart: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ20]
    rise[SYN_TXCLK] && mark_seen_ff |=> quiet_cnt_ff == '0)
    else $error("quiet count not restarted");
  a_irq_enable: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ9]
    drive_monitor_irq |-> $past(cfg.drive_monitor_int_enable) && $past(status_ff))
    else $error("irq without enable");
  a_lock_signal: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ16]
    !sync2_ff[SYN_SIGNAL] |=> rx_lock_lost ##0 rx_clock_uses_reference)
    else $error("no lock loss on missing signal");
  a_lock_freq: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ17]
    win_done && off_freq |=> rx_clock_uses_reference)
    else $error("reference clock not substituted");
  a_monitor_sel: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ10]
    cfg.internal_drive_monitor_sel |-> mon_pos == pos_ff)
    else $error("monitor not on own driver");
  a_status_clear: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ8]
    status_read && !status_set |=> !drive_monitor_int_status)
    else $error("sticky status not cleared by read");
  a_lock_regained: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ18]
    sync2_ff[SYN_SIGNAL] && !off_freq |=> !rx_lock_lost && !rx_clock_uses_reference)
    else $error("recovered clock not selected while locked");
  a_single_neg_idle: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ19]
    $past(cfg.single_rail_select) |-> !tx_line_neg_o)
    else $error("negative rail driven in single-rail");
  a_equalizer_bit: assert property (@(posedge clock) disable iff (!rst_sync_ff) // [RQ13]
    $past(rst_sync_ff) |-> equalizer_enable == $past(cfg.equalizer_in))
    else $error("equalizer not following bit");

  c_alarm_raised: cover property (@(posedge clock) disable iff (!rst_sync_ff)
    $rose(drive_monitor_alarm));
  c_alarm_cleared: cover property (@(posedge clock) disable iff (!rst_sync_ff)
    $fell(drive_monitor_alarm) ##[1:300] !drive_monitor_int_status);
  c_lock_gained: cover property (@(posedge clock) disable iff (!rst_sync_ff)
    $fell(rx_lock_lost));
  c_tx_on: cover property (@(posedge clock) disable iff (!rst_sync_ff)
    $rose(tx_line_pos_oe));

endmodule

// file: sim/lcm_line_model.sv
// Line-side model: coax wiring to the monitor pins and the receive clock source
`timescale 1ns/1ps
module lcm_line_model (
  input  wire logic clock,
  input  wire logic tx_line_pos_o,
  input  wire logic tx_line_pos_oe,
  input  wire logic tx_line_neg_o,
  input  wire logic tx_line_neg_oe,
  input  wire logic reference_clock_in,
  input  wire logic wired,
  input  wire logic freq_good,
  input  wire logic signal_on,
  output logic      monitor_in_pos,
  output logic      monitor_in_neg,
  output logic      rx_signal_present,
  output logic      rx_recovered_clock
);
  logic [2:0] div_ff = 3'h0;
  logic       slow_ff = 1'b0;

  // Terminated line reads zero when released or when the monitor is unwired
  assign monitor_in_pos = wired & tx_line_pos_oe & tx_line_pos_o;
  assign monitor_in_neg = wired & tx_line_neg_oe & tx_line_neg_o;
  assign rx_signal_present = signal_on;
  // Locked case reuses the reference edges so window counts match exactly
  assign rx_recovered_clock = signal_on & (freq_good ? reference_clock_in : slow_ff);

  // Off-frequency clock: period of 10 system clocks against 8
  always @(negedge clock) begin
    div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
    if (div_ff == 3'h4) slow_ff <= ~slow_ff;
  end
endmodule

// file: sim/lcm_ctrl_bench.sv
// Self-checking bench for the line channel control block
`timescale 1ns/1ps
module lcm_ctrl_bench;
  import lcm_pkg::*;
  localparam int WIN = 256;
  logic        clock = 1'b0;
  logic        tx_rate_clock = 1'b0;
  logic        rst_n, transmitter_on_pin, status_read;
  logic        monitor_in_pos, monitor_in_neg, rx_signal_present, rx_recovered_clock;
  logic        wired, freq_good, signal_on, se, en;
  logic        tx_line_pos_o, tx_line_pos_oe, tx_line_neg_o, tx_line_neg_oe;
  logic        encoder_enable, decoder_enable, bpv_as_data, build_out_enable;
  logic        equalizer_enable, monitor_gain_enable, rx_lock_lost, rx_clock_uses_reference;
  logic        drive_monitor_alarm, drive_monitor_int_status, drive_monitor_irq;
  logic [2:0]  tick = 3'h0;
  logic [31:0] rng;
  lcm_cfg_t    cfg;
  lcm_rail_t   tx_data;
  int          n_errors, checked;

  lcm_ctrl #(.WINDOW_CYC(WIN)) DUT (.clock, .rst_n, .cfg, .tx_data, .tx_rate_clock,
    .transmitter_on_pin, .monitor_in_pos, .monitor_in_neg, .rx_signal_present,
    .rx_recovered_clock, .reference_clock_in(tx_rate_clock), .status_read,
    .tx_line_pos_o, .tx_line_pos_oe, .tx_line_neg_o, .tx_line_neg_oe, .encoder_enable,
    .decoder_enable, .bpv_as_data, .build_out_enable, .equalizer_enable,
    .monitor_gain_enable, .drive_monitor_alarm, .drive_monitor_int_status,
    .drive_monitor_irq, .rx_lock_lost, .rx_clock_uses_reference);

  lcm_line_model line (.clock, .tx_line_pos_o, .tx_line_pos_oe, .tx_line_neg_o,
    .tx_line_neg_oe, .reference_clock_in(tx_rate_clock), .wired, .freq_good, .signal_on,
    .monitor_in_pos, .monitor_in_neg, .rx_signal_present, .rx_recovered_clock);

  always #20 clock = ~clock;

  // Tx rate and reference clocks share one period of 8 system clocks
  always @(negedge clock) begin
    tick <= tick + 3'h1;
    if (tick[1:0] == 2'h3) tx_rate_clock <= ~tx_rate_clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches=%0d comparisons=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Bounded poll on the alarm (which=0) or the lock flag (which=1)
  task automatic wait_for(input int which, input logic want, input int max);
    logic v;
    for (int i = 0; i < max; i++) begin
      @(negedge clock);
      v = (which == 0) ? drive_monitor_alarm : rx_lock_lost;
      if (v === want) return;
    end
    n_errors++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, v, want);
    conclude();
  endtask

  task automatic read_status();
    status_read = 1'b1;
    cyc(1);
    status_read = 1'b0;
    cyc(3);
  endtask

  initial begin
    rng = 32'h732D;
    n_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    cfg = '0;
    tx_data = '0;
    transmitter_on_pin = 1'b0;
    status_read = 1'b0;
    wired = 1'b1;
    freq_good = 1'b1;
    signal_on = 1'b1;
    cyc(20);
    rst_n = 1'b1;
    cyc(4);
    for (int k = 0; k < 40; k++) begin
      rng = xs(rng);
      cfg = lcm_cfg_t'(rng[8:0]);
      tx_data = lcm_rail_t'(rng[10:9]);
      transmitter_on_pin = rng[11];
      cyc(6);
      se = cfg.single_rail_select;
      en = cfg.host_mode ? cfg.transmitter_on & transmitter_on_pin : transmitter_on_pin;
      chk({1'b0, encoder_enable, decoder_enable, bpv_as_data}, {1'b0, se, se, ~se});
      chk({3'h0, build_out_enable}, {3'h0, ~cfg.build_out_disable & ~cfg.rate_e3});
      chk({2'h0, equalizer_enable, monitor_gain_enable},
          {2'h0, cfg.equalizer_in, cfg.rx_line_monitor_gain});
      chk({tx_line_pos_oe, tx_line_neg_oe, tx_line_pos_o, tx_line_neg_o},
          {en, en, en & tx_data.pos, en & tx_data.neg & ~se});
    end
    // Long run to the cross-connect and long cable: build-out off, equalizer in
    cfg = '0;
    cfg.build_out_disable = 1'b1;
    cfg.equalizer_in = 1'b1;
    cfg.host_mode = 1'b1;
    cfg.transmitter_on = 1'b1;
    cfg.internal_drive_monitor_sel = 1'b1;
    cfg.drive_monitor_int_enable = 1'b1;
    transmitter_on_pin = 1'b1;
    tx_data = 2'b10;
    cyc(40);
    read_status();
    chk({1'b0, drive_monitor_alarm, drive_monitor_int_status, drive_monitor_irq}, 4'h0);
    tx_data = 2'b00;
    cyc(8 * 90);
    chk({3'h0, drive_monitor_alarm}, 4'h0);
    wait_for(0, 1'b1, 8 * 75);
    cyc(3);
    chk({1'b0, drive_monitor_alarm, drive_monitor_int_status, drive_monitor_irq}, 4'h7);
    tx_data = 2'b10;
    wait_for(0, 1'b0, 40);
    chk({2'h0, drive_monitor_alarm, drive_monitor_int_status}, 4'h1);
    read_status();
    chk({2'h0, drive_monitor_int_status, drive_monitor_irq}, 4'h0);
    // One mark between two quiet stretches that only add up past the limit
    tx_data = 2'b00;
    cyc(8 * 100);
    tx_data = 2'b10;
    cyc(8);
    tx_data = 2'b00;
    cyc(8 * 90);
    chk({3'h0, drive_monitor_alarm}, 4'h0);
    cfg.drive_monitor_int_enable = 1'b0;
    wait_for(0, 1'b1, 8 * 170);
    cyc(3);
    chk({2'h0, drive_monitor_int_status, drive_monitor_irq}, 4'h2);
    tx_data = 2'b01;
    wait_for(0, 1'b0, 40);
    read_status();
    chk({3'h0, drive_monitor_int_status}, 4'h0);
    // External monitor unwired: active own line is not seen
    cfg.internal_drive_monitor_sel = 1'b0;
    wired = 1'b0;
    tx_data = 2'b10;
    wait_for(0, 1'b1, 8 * 170);
    chk({3'h0, drive_monitor_alarm}, 4'h1);
    wired = 1'b1;
    wait_for(0, 1'b0, 40);
    wired = 1'b0;
    cfg.internal_drive_monitor_sel = 1'b1;
    cyc(8 * 170);
    chk({3'h0, drive_monitor_alarm}, 4'h0);
    wait_for(1, 1'b0, 3 * WIN);
    chk({2'h0, rx_lock_lost, rx_clock_uses_reference}, 4'h0);
    signal_on = 1'b0;
    wait_for(1, 1'b1, 6);
    chk({2'h0, rx_lock_lost, rx_clock_uses_reference}, 4'h3);
    signal_on = 1'b1;
    wait_for(1, 1'b0, 3 * WIN);
    freq_good = 1'b0;
    wait_for(1, 1'b1, 3 * WIN);
    chk({2'h0, rx_lock_lost, rx_clock_uses_reference}, 4'h3);
    freq_good = 1'b1;
    wait_for(1, 1'b0, 3 * WIN);
    chk({2'h0, rx_lock_lost, rx_clock_uses_reference}, 4'h0);
    // Mid-run reset: outputs fall to reset levels, lock lost until a clean window
    rst_n = 1'b0;
    cyc(2);
    chk({tx_line_pos_oe, tx_line_neg_oe, encoder_enable, drive_monitor_int_status},
        4'h0);
    chk({2'h0, rx_lock_lost, rx_clock_uses_reference}, 4'h3);
    rst_n = 1'b1;
    wait_for(1, 1'b0, 3 * WIN);
    chk({2'h0, equalizer_enable, build_out_enable},
        {2'h0, cfg.equalizer_in, ~cfg.build_out_disable & ~cfg.rate_e3});
    conclude();
  end
endmodule
